//--- verilog/cmdsel_map.vh
// Constants of the command source selector: codes, defaults, timing.
// Assumes inclusion by bare name from the design files of this block.
`ifndef CMDSEL_MAP_VH
`define CMDSEL_MAP_VH
// Reset source codes
`define CMDSEL_RST_TERM 3'h0
`define CMDSEL_RST_KEYB 3'h1
`define CMDSEL_RST_COM 3'h2
`define CMDSEL_RST_TERM_KEYB 3'h3
`define CMDSEL_RST_COM_KEYB 3'h4
`define CMDSEL_RST_ALL 3'h5
`define CMDSEL_RST_DEFAULT 3'h3
// Normal and local source codes
`define CMDSEL_SRC_TERM 2'h0
`define CMDSEL_SRC_KEYB 2'h1
`define CMDSEL_SRC_COM 2'h2
`define CMDSEL_LOC_STANDARD 2'h0
`define CMDSEL_LOC_TERM 2'h1
`define CMDSEL_LOC_KEYB 2'h2
`define CMDSEL_LOC_COM 2'h3
`define CMDSEL_LOC_DEFAULT 2'h0
// Level or edge qualification
`define CMDSEL_MODE_LEVEL 1'b0
`define CMDSEL_MODE_EDGE 1'b1
// Keyboard lock code and field limit
`define CMDSEL_LOCK_CODE 14'h0123
`define CMDSEL_LOCK_MAX 14'h270F
// Supply classes
`define CMDSEL_SUP_UNDEF 3'h0
`define CMDSEL_SUP_MIN 3'h1
`define CMDSEL_SUP_MAX 3'h7
// Synchroniser depth for terminal inputs
`define CMDSEL_SYNC_STAGES 3
`endif

//--- verilog/cmdsel_term_qual.v
// Qualifies one terminal input: synchroniser, edge detect, level/edge mode.
// Assumes an asynchronous pin and one system clock.
`timescale 1ns/1ps
`default_nettype none
`include "cmdsel_map.vh"
module cmdsel_term_qual (
   input wire clk_sys,
   input wire nrst,
   input wire pin_in,
   input wire edge_mode,
   output reg level_act,
   output reg rise_pulse,
   output reg fall_pulse,
   output wire active
);
   reg [`CMDSEL_SYNC_STAGES-1:0] sync_reg; // Shift chain from the pin
   reg stable_reg; // Accepted level after stages agree
   wire agree;
   // Change counts only when second and third stage agree
   assign agree = (sync_reg[1] == sync_reg[2]);
   // Synchroniser and edge capture
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync_reg <= {`CMDSEL_SYNC_STAGES{1'b0}};
         stable_reg <= 1'b0;
         level_act <= 1'b0;
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end else begin
         sync_reg <= {sync_reg[`CMDSEL_SYNC_STAGES-2:0], pin_in}; // [RL18]
         if (agree) begin
            stable_reg <= sync_reg[2];
         end
         level_act <= agree ? sync_reg[2] : stable_reg; // [RL12]
         // One-cycle pulses against previous accepted value
         rise_pulse <= agree & sync_reg[2] & ~stable_reg; // [RL18]
         fall_pulse <= agree & ~sync_reg[2] & stable_reg;
      end
   end
   // Edge mode acts on the rising pulse, level mode on the held level
   assign active = edge_mode ? rise_pulse : level_act; // [RL11] [RL13]
endmodule
`default_nettype wire

//--- verilog/cmdsel_supply.v
// Mains supply class store and brake chopper threshold.
// Assumes commands are single-cycle pulses on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "cmdsel_map.vh"
module cmdsel_supply (
   input wire clk_sys,
   input wire nrst,
   input wire sup_wr,
   input wire [2:0] sup_wr_val,
   input wire sup_load,
   input wire [2:0] sup_load_val,
   input wire load_default,
   output reg [2:0] supply_class,
   output wire supply_undefined,
   output reg [10:0] chopper_level_v
);
   reg [2:0] class_next;
   reg [9:0] ac_v; // Nominal top of each AC class in volts
   reg [17:0] dc_full; // Full-width DC product before the cut to 11 bits
   // Valid class: 1 or 3..7, never 0 again
   function valid_class;
      input [2:0] c;
      begin
         valid_class = (c != `CMDSEL_SUP_UNDEF) && (c != 3'h2);
      end
   endfunction
   // Next class; default load has no path here
   always @* begin
      class_next = supply_class;
      if (sup_load && valid_class(sup_load_val)) begin
         class_next = sup_load_val; // [RL16]
      end else if (sup_wr && valid_class(sup_wr_val)) begin
         class_next = sup_wr_val; // [RL14] [RL15]
      end
   end
   // AC top voltage per class, zero means inverter default
   always @* begin
      case (supply_class)
         3'h1: ac_v = 10'd240;
         3'h3: ac_v = 10'd415;
         3'h4: ac_v = 10'd480;
         3'h5: ac_v = 10'd525;
         3'h6: ac_v = 10'd600;
         3'h7: ac_v = 10'd690;
         default: ac_v = 10'd0;
      endcase
   end
   // DC bus is 1.34 x AC, 134/100 in integer volts; top class gives 924
   always @* begin
      dc_full = ({8'h00, ac_v} * 18'd134) / 18'd100; // [RL17]
   end
   // Store class; load_default deliberately ignored
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         supply_class <= `CMDSEL_SUP_UNDEF;
         chopper_level_v <= 11'h000;
      end else begin
         supply_class <= class_next;
         // Quotient never exceeds 11 bits, so the cut drops only zeros
         chopper_level_v <= dc_full[10:0]; // [RL17]
      end
   end
   assign supply_undefined = (supply_class == `CMDSEL_SUP_UNDEF); // [RL15]
endmodule
`default_nettype wire

//--- verilog/cmdsel_top.v
// Command source selector: reset, reference and run/stop source logic.
// Assumes pins asynchronous, keyboard and serial strobes on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "cmdsel_map.vh"
// What this block does
// RL1 - Faulted unit waits for selected reset
// RL2 - Codes 0,1,2 pick terminal, keys, serial
// RL3 - Codes 3,4,5 combine sources; default 3
// RL4 - Local reference source codes 0..3
// RL5 - Local run/stop source codes 0..3
// RL6 - Both standard disables local swap
// RL7 - Toggle key or input swaps modes
// RL8 - Code 291 toggles keyboard lock
// RL9 - Show lock or unlock prompt
// RL10 - Lock blocks key parameter writes only
// RL11 - Level/edge applies to three inputs
// RL12 - Level mode: active while high
// RL13 - Edge mode: rise runs, fall stops
// RL14 - Supply class codes 1, 3..7
// RL15 - Not-defined only until first set
// RL16 - Default load keeps class, panel overwrites
// RL17 - Chopper level from class times 1.34
// RL18 - Three-stage sync, edge pulses
// RL19 - Normal run source codes 0,1,2
module cmdsel_top (
   input wire clk_sys,
   input wire nrst,
   input wire [2:0] reset_source,
   input wire [1:0] ref_source,
   input wire [1:0] runstop_source,
   input wire [1:0] local_reference_source,
   input wire [1:0] local_runstop_source,
   input wire level_edge_mode,
   input wire run_right_input,
   input wire run_left_input,
   input wire reset_input,
   input wire local_select_input,
   input wire key_toggle_second,
   input wire key_reset,
   input wire key_run_right,
   input wire key_run_left,
   input wire key_stop,
   input wire key_param_wr,
   input wire key_ref_wr,
   input wire key_lock_wr,
   input wire [13:0] key_lock_val,
   input wire com_reset,
   input wire com_run_right,
   input wire com_run_left,
   input wire com_stop,
   input wire fault,
   input wire sup_wr,
   input wire [2:0] sup_wr_val,
   input wire sup_load,
   input wire [2:0] sup_load_val,
   input wire load_default,
   output reg local_mode,
   output reg [1:0] eff_ref_source,
   output reg [1:0] eff_run_source,
   output reg faulted,
   output reg run_right,
   output reg run_left,
   output reg keyboard_locked,
   output wire prompt_lock,
   output wire prompt_unlock,
   output wire param_wr_ok,
   output wire ref_wr_ok,
   output wire [2:0] supply_class,
   output wire supply_undefined,
   output wire [10:0] chopper_level_v
);
   // Terminal input qualification
   wire rr_act, rl_act, rs_act;
   wire rr_fall, rl_fall;
   wire rr_lvl, rl_lvl, rs_lvl, loc_lvl;
   wire loc_rise;
   wire unused_pulses;
   reg [1:0] rst_code_ok; // Unused guard, reserved for bad codes
   reg loc_prev_reg;
   reg toggle_prev_reg;
   reg reset_sel; // Reset request from allowed sources
   reg run_r_cmd, run_l_cmd, stop_cmd; // Commands from the run source
   reg local_next;
   reg [1:0] run_src_eff;
   wire swap_enabled;
   wire lock_hit;

   cmdsel_term_qual u_rr (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_in(run_right_input),
      .edge_mode(level_edge_mode),
      .level_act(rr_lvl),
      .rise_pulse(),
      .fall_pulse(rr_fall),
      .active(rr_act)
   );
   cmdsel_term_qual u_rl (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_in(run_left_input),
      .edge_mode(level_edge_mode),
      .level_act(rl_lvl),
      .rise_pulse(),
      .fall_pulse(rl_fall),
      .active(rl_act)
   );
   cmdsel_term_qual u_rs (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_in(reset_input),
      .edge_mode(level_edge_mode),
      .level_act(rs_lvl),
      .rise_pulse(),
      .fall_pulse(),
      .active(rs_act)
   );
   // Local select pin always acts on its rising edge
   cmdsel_term_qual u_loc (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_in(local_select_input),
      .edge_mode(1'b1),
      .level_act(loc_lvl),
      .rise_pulse(),
      .fall_pulse(),
      .active(loc_rise)
   );
   assign unused_pulses = rs_lvl ^ loc_lvl;

   cmdsel_supply u_sup (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .sup_wr(sup_wr),
      .sup_wr_val(sup_wr_val),
      .sup_load(sup_load),
      .sup_load_val(sup_load_val),
      .load_default(load_default),
      .supply_class(supply_class),
      .supply_undefined(supply_undefined),
      .chopper_level_v(chopper_level_v)
   );

   // Reset source multiplexer, combined codes OR their sources
   always @* begin
      rst_code_ok = 2'h0;
      case (reset_source)
         `CMDSEL_RST_TERM: reset_sel = rs_act; // [RL2]
         `CMDSEL_RST_KEYB: reset_sel = key_reset; // [RL2]
         `CMDSEL_RST_COM: reset_sel = com_reset; // [RL2]
         `CMDSEL_RST_TERM_KEYB: reset_sel = rs_act | key_reset; // [RL3]
         `CMDSEL_RST_COM_KEYB: reset_sel = com_reset | key_reset; // [RL3]
         `CMDSEL_RST_ALL: reset_sel = rs_act | key_reset | com_reset; // [RL3]
         // Unused codes accept nothing; a fault stays latched
         default: reset_sel = 1'b0;
      endcase
   end

   // Swap is only meaningful if a local source is set
   assign swap_enabled = (local_reference_source != `CMDSEL_LOC_STANDARD) ||
      (local_runstop_source != `CMDSEL_LOC_STANDARD); // [RL6]

   // Local mode toggles on key second function or local input edge
   always @* begin
      local_next = local_mode;
      if (!swap_enabled) begin
         local_next = 1'b0; // [RL6]
      end else if ((key_toggle_second && !toggle_prev_reg) || loc_rise) begin
         local_next = ~local_mode; // [RL7]
      end
   end

   // Effective run source; local code n maps to normal code n-1
   always @* begin
      if (local_mode && local_runstop_source != `CMDSEL_LOC_STANDARD) begin
         run_src_eff = local_runstop_source - 2'h1; // [RL5]
      end else begin
         run_src_eff = runstop_source; // [RL19]
      end
   end

   // Run and stop commands from the effective source
   always @* begin
      run_r_cmd = 1'b0;
      run_l_cmd = 1'b0;
      stop_cmd = 1'b0;
      if (run_src_eff == `CMDSEL_SRC_TERM) begin
         run_r_cmd = rr_act; // [RL12] [RL13]
         run_l_cmd = rl_act;
         // Level mode stops on low level, edge mode on falling edge
         if (level_edge_mode == `CMDSEL_MODE_EDGE) begin
            stop_cmd = rr_fall | rl_fall; // [RL13]
         end else begin
            stop_cmd = ~rr_lvl & ~rl_lvl; // [RL12]
         end
      end else if (run_src_eff == `CMDSEL_SRC_KEYB) begin
         // Keys stay usable while locked
         run_r_cmd = key_run_right; // [RL10]
         run_l_cmd = key_run_left;
         stop_cmd = key_stop;
      end else if (run_src_eff == `CMDSEL_SRC_COM) begin
         run_r_cmd = com_run_right;
         run_l_cmd = com_run_left;
         stop_cmd = com_stop;
      end
   end

   // Lock code match within the field range
   assign lock_hit = key_lock_wr && (key_lock_val == `CMDSEL_LOCK_CODE) &&
      (key_lock_val <= `CMDSEL_LOCK_MAX); // [RL8]

   // Main state: local mode, fault latch, run outputs, lock
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         local_mode <= 1'b0;
         toggle_prev_reg <= 1'b0;
         loc_prev_reg <= 1'b0;
         eff_ref_source <= `CMDSEL_SRC_KEYB;
         eff_run_source <= `CMDSEL_SRC_KEYB;
         faulted <= 1'b0;
         run_right <= 1'b0;
         run_left <= 1'b0;
         keyboard_locked <= 1'b0;
      end else begin
         local_mode <= local_next;
         toggle_prev_reg <= key_toggle_second;
         loc_prev_reg <= unused_pulses;
         eff_run_source <= run_src_eff;
         if (local_mode && local_reference_source != `CMDSEL_LOC_STANDARD) begin
            eff_ref_source <= local_reference_source - 2'h1; // [RL4]
         end else begin
            eff_ref_source <= ref_source;
         end
         // Fault wins over reset; reset needs the selected source
         if (fault) begin
            faulted <= 1'b1; // [RL1]
         end else if (reset_sel) begin
            faulted <= 1'b0; // [RL1]
         end
         // No run while faulted; stop has priority over run
         if (fault || faulted || stop_cmd) begin
            run_right <= 1'b0; // [RL1]
            run_left <= 1'b0;
         end else if (level_edge_mode == `CMDSEL_MODE_LEVEL &&
            run_src_eff == `CMDSEL_SRC_TERM) begin
            run_right <= run_r_cmd; // [RL12]
            run_left <= run_l_cmd & ~run_r_cmd;
         end else if (run_r_cmd) begin
            run_right <= 1'b1; // [RL13]
            run_left <= 1'b0;
         end else if (run_l_cmd) begin
            run_right <= 1'b0;
            run_left <= 1'b1;
         end
         if (lock_hit) begin
            keyboard_locked <= ~keyboard_locked; // [RL8]
         end
      end
   end

   // Prompt shows current lock state
   assign prompt_lock = ~keyboard_locked; // [RL9]
   assign prompt_unlock = keyboard_locked; // [RL9]
   // Parameter writes from keys blocked; lock entry itself stays open
   assign param_wr_ok = key_param_wr & ~keyboard_locked; // [RL10]
   // Reference edits allowed while locked if keyboard is the source
   assign ref_wr_ok = key_ref_wr && (eff_ref_source == `CMDSEL_SRC_KEYB); // [RL10]
endmodule
`default_nettype wire

//--- tb/cmdsel_far_side.sv
// Terminal strip model: the four digital inputs of the selector.
// Assumes levels asked for by the bench; contacts move on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module cmdsel_far_side (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic [3:0] want,
   output var logic [3:0] pins
);
   // Extra stage stands for a slow relay contact
   logic [3:0] lag_reg = 4'h0;
   initial pins = 4'h0;
   // Pins settle well away from the sampling edge
   always @(negedge clk_sys) begin
      lag_reg <= want;
      pins <= slow ? lag_reg : want;
   end
endmodule
`default_nettype wire

//--- tb/cmdsel_top_properties.sv
// Port checker for the command source selector.
// Assumes one clock and nrst active low; bound onto cmdsel_top.
`timescale 1ns/1ps
`default_nettype none
module cmdsel_checker (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [2:0] reset_source,
   input wire logic [1:0] local_reference_source,
   input wire logic [1:0] local_runstop_source,
   input wire logic key_reset,
   input wire logic com_reset,
   input wire logic fault,
   input wire logic key_lock_wr,
   input wire logic [13:0] key_lock_val,
   input wire logic key_param_wr,
   input wire logic local_mode,
   input wire logic [1:0] eff_run_source,
   input wire logic faulted,
   input wire logic keyboard_locked,
   input wire logic param_wr_ok,
   input wire logic [2:0] supply_class
);
   // One domain, so clock and reset are stated once
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // Lock code 291 entered at the panel
   wire lock_hit = key_lock_wr && key_lock_val == 14'h0123;
   // Reset strobes let through by the selected code
   wire reset_ok = key_reset && reset_source inside {3'h1, 3'h3, 3'h4, 3'h5} ||
      com_reset && reset_source inside {3'h2, 3'h4, 3'h5};
   lock_flip_a: assert property (lock_hit |=> keyboard_locked != $past(keyboard_locked))
      else $error("lock did not toggle");
   locked_write_a: assert property (keyboard_locked && key_param_wr |-> !param_wr_ok)
      else $error("write granted while locked");
   fault_trip_a: assert property (fault |=> faulted)
      else $error("fault not latched");
   reset_refuse_a: assert property (
      faulted && !fault && !com_reset && reset_source == 3'h2 |=> faulted)
      else $error("reset taken from wrong source");
   reset_take_a: assert property (faulted && !fault && reset_ok |=> !faulted)
      else $error("selected reset ignored");
   local_off_a: assert property (
      local_reference_source == 2'h0 && local_runstop_source == 2'h0 |=> !local_mode)
      else $error("local mode while disabled");
   local_run_a: assert property (
      local_mode && local_runstop_source != 2'h0 |=>
      eff_run_source == $past(local_runstop_source) - 2'h1)
      else $error("local run source wrong");
   class_stick_a: assert property (supply_class != 3'h0 |=> supply_class != 3'h0)
      else $error("supply class undefined again");
   // Main scenarios reached
   cover property (lock_hit);
   cover property (faulted ##1 !faulted);
   cover property (local_mode);
endmodule
bind cmdsel_top cmdsel_checker cmdsel_checker_i (.*);
`default_nettype wire

//--- tb/test_command_source_select.sv
// Self-checking bench for the command source selector.
// Assumes the checker is bound; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_command_source_select;
   // Inputs, all given at time zero
   logic clk_sys = 1'b0, nrst = 1'b0, slow = 1'b0;
   logic [2:0] reset_source = 3'h3, sup_wr_val = 3'h0, sup_load_val = 3'h0;
   logic [1:0] ref_source = 2'h1, runstop_source = 2'h1;
   logic [1:0] local_reference_source = 2'h0, local_runstop_source = 2'h0;
   logic level_edge_mode = 1'b0, key_toggle_second = 1'b0, key_reset = 1'b0, key_stop = 1'b0;
   logic key_run_right = 1'b0, key_param_wr = 1'b0, key_ref_wr = 1'b0, key_lock_wr = 1'b0;
   logic com_reset = 1'b0, fault = 1'b0, sup_wr = 1'b0, sup_load = 1'b0, load_default = 1'b0;
   logic com_run_right = 1'b0, com_stop = 1'b0;
   logic [13:0] key_lock_val = 14'h0000;
   logic [3:0] want = 4'h0;
   // Outputs and terminal pins
   wire local_mode, faulted, run_right, run_left, keyboard_locked, prompt_lock, prompt_unlock;
   wire param_wr_ok, ref_wr_ok, supply_undefined;
   wire [3:0] pins;
   wire [1:0] eff_ref_source, eff_run_source;
   wire [2:0] supply_class;
   wire [10:0] chopper_level_v;
   // Model: channels accepted per reset code (bit 0 terminal, 1 keys, 2 serial)
   logic [2:0] acc [6] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h6, 3'h7};
   // Model: top AC volts of each supply class
   int top_volt [8] = '{0, 240, 0, 415, 480, 525, 600, 690};
   int n_fail = 0, checked = 0, r;
   cmdsel_far_side cmdsel_far_side_i (.clk_sys, .slow, .want, .pins);
   // Serial and key left-run strobes stay idle; serial right run and stop are exercised
   cmdsel_top cmdsel_top_i (.run_right_input(pins[0]), .run_left_input(pins[1]),
      .reset_input(pins[2]), .local_select_input(pins[3]), .key_run_left(1'b0),
      .com_run_left(1'b0), .*);
   always #5 clk_sys = ~clk_sys;
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compare, count, report at once
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %0h not %0h", $time, got, exp);
      end
   endtask
   // One-cycle strobe; returns once its effect has landed
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
      @(negedge clk_sys);
   endtask
   // Bounded wait on a run output; a miss ends the run
   task automatic wait_run(input logic left, input logic exp);
      for (int i = 0; i < 12 && (left ? run_left : run_right) !== exp; i++)
         @(negedge clk_sys);
      chk(left ? run_left : run_right, exp);
      if ((left ? run_left : run_right) !== exp)
         summarize();
   endtask
   initial begin
      r = $urandom(32'hE6D104C4);
      repeat (20) @(negedge clk_sys);
      nrst = 1'b1;
      @(negedge clk_sys);
      chk(supply_undefined, 1'b1);
      chk(prompt_lock, 1'b1);
      // A wrong code is ignored, 291 locks; keys keep run/stop
      key_lock_val = 14'($urandom % 9999);
      if (key_lock_val == 14'h0123)
         key_lock_val = 14'h0124;
      pulse(key_lock_wr);
      chk(keyboard_locked, 1'b0);
      key_lock_val = 14'h0123;
      pulse(key_lock_wr);
      chk(prompt_unlock, 1'b1);
      key_param_wr = 1'b1;
      key_ref_wr = 1'b1;
      #1 chk(param_wr_ok, 1'b0);
      chk(ref_wr_ok, 1'b1);
      key_param_wr = 1'b0;
      key_ref_wr = 1'b0;
      pulse(key_run_right);
      chk(run_right, 1'b1);
      pulse(key_stop);
      chk(run_right, 1'b0);
      pulse(key_lock_wr);
      chk(keyboard_locked, 1'b0);
      // Each reset code against each channel; the fault re-arms every time
      for (int code = 0; code < 6; code++) begin
         for (int ch = 0; ch < 3; ch++) begin
            reset_source = 3'(code);
            pulse(fault);
            chk(faulted, 1'b1);
            if (ch == 0) begin
               want[2] = 1'b1;
               repeat (8) @(negedge clk_sys);
               want[2] = 1'b0;
               repeat (8) @(negedge clk_sys);
            end else if (ch == 1)
               pulse(key_reset);
            else
               pulse(com_reset);
            chk(faulted, !acc[code][ch]);
         end
      end
      // Terminal run, level then edge; edge needs a fresh rise after a trip
      reset_source = 3'h3;
      runstop_source = 2'h0;
      for (int m = 0; m < 2; m++) begin
         level_edge_mode = m[0];
         slow = 1'($urandom % 2);
         want[1] = 1'b1;
         wait_run(1'b1, 1'b1);
         want[1] = 1'b0;
         wait_run(1'b1, 1'b0);
         want[0] = 1'b1;
         wait_run(1'b0, 1'b1);
         pulse(fault);
         pulse(key_reset);
         repeat (6) @(negedge clk_sys);
         chk(run_right, !m[0]);
         want[0] = 1'b0;
         repeat (8) @(negedge clk_sys);
      end
      // Swap is dead with both local sources standard
      runstop_source = 2'h1;
      pulse(key_toggle_second);
      chk(local_mode, 1'b0);
      local_runstop_source = 2'h3;
      pulse(key_toggle_second);
      chk(local_mode, 1'b1);
      chk(eff_run_source, 2'h2);
      chk(eff_ref_source, 2'h1);
      for (int n = 1; n < 4; n++) begin
         local_reference_source = 2'(n);
         repeat (2) @(negedge clk_sys);
         chk(eff_ref_source, n - 1);
      end
      want[3] = 1'b1;
      repeat (8) @(negedge clk_sys);
      want[3] = 1'b0;
      chk(local_mode, 1'b0);
      // Normal run source on the serial link
      runstop_source = 2'h2;
      pulse(com_run_right);
      chk(run_right, 1'b1);
      pulse(com_stop);
      chk(run_right, 1'b0);
      // Supply class: undefined cannot be chosen, default load keeps it
      pulse(sup_wr);
      chk(supply_undefined, 1'b1);
      for (int c = 1; c < 8; c++) begin
         if (c != 2) begin
            sup_wr_val = 3'(c);
            pulse(sup_wr);
            chk(supply_class, c);
            chk(chopper_level_v, top_volt[c] * 134 / 100);
         end
      end
      sup_wr_val = 3'h0;
      pulse(sup_wr);
      chk(supply_class, 3'h7);
      pulse(load_default);
      chk(supply_class, 3'h7);
      sup_load_val = 3'($urandom % 4 + 3);
      pulse(sup_load);
      chk(supply_class, sup_load_val);
      summarize();
   end
endmodule
`default_nettype wire
